/* File: src/pwrctl_top.sv */
// Power control register with mode outputs and status flag clears
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pwrctl_regs.svh"
// Operation
// - Control register at offset zero, 32 bits
// - Reset value 0x8000, also on standby wake
// - Half-word and word accesses accepted
// - Bit 21 powers off third SRAM bank
// - Bit 20 powers off second SRAM bank
// - Bit 18 selects low-drive deep-sleep
// - Bit 15 selects over-voltage threshold
// - Bit 14 enables over-voltage detector
// - Bit 8 gates backup domain writes
// - Bits 7:5 select under-voltage threshold
// - Bit 4 enables under-voltage detector
// - Lock makes under-voltage fields read-only
// - Bit 3 write-one clears standby flag
// - Bit 2 write-one clears wake flag
// - Bit 1 picks standby over deep-sleep
// - Bit 0 sets regulator low-power in deep-sleep
// - Oscillator user forces regulator normal mode
// - Standby flag cleared by power reset or strobe
// - Wake flag cleared by reset or strobe
module pwrctl_top (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic standby_wake_i,
  input wire logic undervoltage_cfg_lock_i,
  input wire logic deep_sleep_request_i,
  input wire logic internal_8mhz_osc_busy_i,
  output pwrctl_pkg::pwrctl_mode_e mode_o,
  output logic sram_bank2_power_off_o,
  output logic sram_bank1_power_off_o,
  output logic low_drive_enable_o,
  output logic overvoltage_threshold_sel_o,
  output logic overvoltage_detect_en_o,
  output logic backup_write_en_o,
  output logic [2:0] undervoltage_threshold_o,
  output logic undervoltage_detect_en_o,
  output logic regulator_low_power_o,
  output logic standby_flag_clear_o,
  output logic wake_flag_clear_o
);
  import pwrctl_pkg::*;
  pwrctl_wb_if req ();
  logic hit;
  pwrctl_word_t ctrl_r;
  pwrctl_word_t ctrl_nxt;
  pwrctl_word_t wmask;
  logic stby_clr_r;
  logic wake_clr_r;
  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  pwrctl_wb_front u_front (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .ack_o(ack_o),
    .hit_o(hit),
    .req(req)
  );
  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Lock freezes the under-voltage fields
  always_comb
  begin
    wmask = `PWRCTL_CTRL_WMASK & req.bmask;
    if (undervoltage_cfg_lock_i)
      wmask = wmask & ~`PWRCTL_UV_MASK;
    ctrl_nxt = (ctrl_r & ~wmask) | (req.wdata & wmask);
  end
  // Wake from standby reloads reset value
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ctrl_r <= `PWRCTL_CTRL_RESET;
    else if (standby_wake_i)
      ctrl_r <= `PWRCTL_CTRL_RESET;
    else if (req.wr)
      ctrl_r <= ctrl_nxt;
  end
  // ----------------------------------------
  // Flag clear strobes
  // ----------------------------------------
  // One-cycle pulses; the flags live in the status block
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stby_clr_r <= 1'b0;
      wake_clr_r <= 1'b0;
    end
    else
    begin
      stby_clr_r <= req.wr && req.bmask[`PWRCTL_BIT_STBY_CLR]
                    && req.wdata[`PWRCTL_BIT_STBY_CLR];
      wake_clr_r <= req.wr && req.bmask[`PWRCTL_BIT_WAKE_CLR]
                    && req.wdata[`PWRCTL_BIT_WAKE_CLR];
    end
  end
  assign standby_flag_clear_o = stby_clr_r;
  assign wake_flag_clear_o = wake_clr_r;
  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Strobe bits never stored, so they read zero
  assign dat_o = hit ? ctrl_r : 32'h0000_0000;
  // ----------------------------------------
  // Mode outputs
  // ----------------------------------------
  assign sram_bank2_power_off_o = ctrl_r[`PWRCTL_BIT_SRAM2_OFF];
  assign sram_bank1_power_off_o = ctrl_r[`PWRCTL_BIT_SRAM1_OFF];
  assign low_drive_enable_o = ctrl_r[`PWRCTL_BIT_LOW_DRIVE];
  assign overvoltage_threshold_sel_o = ctrl_r[`PWRCTL_BIT_OV_THRESH];
  assign overvoltage_detect_en_o = ctrl_r[`PWRCTL_BIT_OV_EN];
  assign backup_write_en_o = ctrl_r[`PWRCTL_BIT_BKP_WEN];
  assign undervoltage_threshold_o =
    ctrl_r[`PWRCTL_UV_THRESH_HI:`PWRCTL_UV_THRESH_LO];
  assign undervoltage_detect_en_o = ctrl_r[`PWRCTL_BIT_UV_EN];
  // Regulator stays normal while the oscillator has a user
  assign regulator_low_power_o = ctrl_r[`PWRCTL_BIT_REG_LP]
                                 && !internal_8mhz_osc_busy_i;
  always_comb
  begin
    if (!deep_sleep_request_i)
      mode_o = PWRCTL_RUN;
    else if (ctrl_r[`PWRCTL_BIT_STBY_SEL])
      mode_o = PWRCTL_STBY;
    else
      mode_o = PWRCTL_DEEP;
  end
endmodule : pwrctl_top
`default_nettype wire

/* File: src/pwrctl_regs.svh */
// Register offsets, field positions and reset values of the power control
`ifndef PWRCTL_REGS_SVH
`define PWRCTL_REGS_SVH

`define PWRCTL_BASE_ADDR 32'h4000_7000
`define PWRCTL_CTRL_OFFSET 4'h0
`define PWRCTL_CTRL_RESET 32'h0000_8000
`define PWRCTL_CTRL_WMASK 32'h0034_C1F3
`define PWRCTL_BIT_SRAM2_OFF 21
`define PWRCTL_BIT_SRAM1_OFF 20
`define PWRCTL_BIT_LOW_DRIVE 18
`define PWRCTL_BIT_OV_THRESH 15
`define PWRCTL_BIT_OV_EN 14
`define PWRCTL_BIT_BKP_WEN 8
`define PWRCTL_UV_THRESH_HI 7
`define PWRCTL_UV_THRESH_LO 5
`define PWRCTL_BIT_UV_EN 4
`define PWRCTL_BIT_STBY_CLR 3
`define PWRCTL_BIT_WAKE_CLR 2
`define PWRCTL_BIT_STBY_SEL 1
`define PWRCTL_BIT_REG_LP 0
`define PWRCTL_UV_MASK 32'h0000_00F0

`endif

/* File: src/pwrctl_pkg.sv */
// Types shared by the power control register files
package pwrctl_pkg;
  typedef enum logic [1:0] {
    PWRCTL_RUN = 2'b00,
    PWRCTL_DEEP = 2'b01,
    PWRCTL_STBY = 2'b11
  } pwrctl_mode_e;
  typedef logic [31:0] pwrctl_word_t;
endpackage : pwrctl_pkg

/* File: src/pwrctl_wb_if.sv */
// Internal bus-request carrier between the slave front end and the register
`timescale 1ns/1ps
`default_nettype none
interface pwrctl_wb_if;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] bmask;
  modport front (output wr, output wdata, output bmask);
  modport back (input wr, input wdata, input bmask);
endinterface : pwrctl_wb_if
`default_nettype wire

/* File: src/pwrctl_wb_front.sv */
// Wishbone classic slave front end for one register word
`timescale 1ns/1ps
`default_nettype none
`include "pwrctl_regs.svh"
module pwrctl_wb_front (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic ack_o,
  output logic hit_o,
  pwrctl_wb_if.front req
);
  import pwrctl_pkg::*;
  logic ack_r;
  logic req_live;
  // ----------------------------------------
  // Handshake
  // ----------------------------------------
  // One ack per request; gap cycle prevents a double write
  assign req_live = cyc_i && stb_i && !ack_r;
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ack_r <= 1'b0;
    else
      ack_r <= req_live;
  end
  assign ack_o = ack_r;
  assign hit_o = (adr_i == `PWRCTL_CTRL_OFFSET);
  // Byte lanes are honoured; half-word and word both fit
  // Write lands on the edge where the master samples ack
  assign req.wr = cyc_i && stb_i && ack_r && we_i && hit_o;
  assign req.wdata = dat_i;
  assign req.bmask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                      {8{sel_i[1]}}, {8{sel_i[0]}}};
endmodule : pwrctl_wb_front
`default_nettype wire

/* File: bench/pwrctl_monitor.sv */
// Bus timing and field checks on the power control register
`timescale 1ns/1ps
`default_nettype none
module pwrctl_monitor (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic standby_wake_i,
  input wire logic undervoltage_cfg_lock_i,
  input wire logic internal_8mhz_osc_busy_i,
  input wire logic overvoltage_threshold_sel_o,
  input wire logic backup_write_en_o,
  input wire logic [2:0] undervoltage_threshold_o,
  input wire logic undervoltage_detect_en_o,
  input wire logic regulator_low_power_o,
  input wire logic standby_flag_clear_o,
  input wire logic wake_flag_clear_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_ack_taken: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack long");
  chk_stby_clear: assert property (standby_flag_clear_o == $past(ack_o
    && cyc_i && stb_i && we_i && sel_i[0] && dat_i[3] && adr_i == 4'h0))
    else $error("standby clear");
  chk_wake_clear: assert property (wake_flag_clear_o == $past(ack_o
    && cyc_i && stb_i && we_i && sel_i[0] && dat_i[2] && adr_i == 4'h0))
    else $error("wake clear");
  chk_osc_normal: assert property (regulator_low_power_o |->
    !internal_8mhz_osc_busy_i) else $error("low power with osc busy");
  chk_bkp_cause: assert property ($changed(backup_write_en_o) |->
    $past(ack_o && we_i) || $past(standby_wake_i))
    else $error("backup enable moved");
  chk_uv_locked: assert property ($past(undervoltage_cfg_lock_i) &&
    !$past(standby_wake_i) |-> $stable({undervoltage_threshold_o,
    undervoltage_detect_en_o})) else $error("locked field moved");
  chk_wake_reload: assert property ($past(standby_wake_i) |->
    overvoltage_threshold_sel_o && !backup_write_en_o) else $error("no reload");
  chk_unmapped_quiet: assert property (ack_o && adr_i != 4'h0
    && !standby_wake_i |=> $stable(backup_write_en_o))
    else $error("unmapped write hit");
  cov_lock_write: cover property (ack_o && we_i && undervoltage_cfg_lock_i);
  cov_wake: cover property (standby_wake_i);
  cov_clear: cover property (standby_flag_clear_o && wake_flag_clear_o);
endmodule : pwrctl_monitor
bind pwrctl_top pwrctl_monitor pwrctl_monitor_i (.*);
`default_nettype wire

/* File: bench/pwrctl_top_tb.sv */
// Self-checking bench for the power control register
`timescale 1ns/1ps
`default_nettype none
module pwrctl_top_tb;
  import pwrctl_pkg::*;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic wk = 0, lk = 0, ds = 0, os = 0, ack, sc, wc, rlp;
  logic [3:0] adr = 0, sel = 0, a, s;
  logic [31:0] dat = 0, rd, q, d, m, e = 32'h0000_8000;
  wire logic [9:0] f;
  pwrctl_mode_e md;
  int n_mismatch = 0, n_checks = 0, i;
  pwrctl_top pwrctl_top_i (.sys_clk_i(clk), .reset_n_i(rst_n), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(rd), .ack_o(ack), .standby_wake_i(wk),
    .undervoltage_cfg_lock_i(lk), .deep_sleep_request_i(ds),
    .internal_8mhz_osc_busy_i(os), .mode_o(md),
    .sram_bank2_power_off_o(f[9]), .sram_bank1_power_off_o(f[8]),
    .low_drive_enable_o(f[7]), .overvoltage_threshold_sel_o(f[6]),
    .overvoltage_detect_en_o(f[5]), .backup_write_en_o(f[4]),
    .undervoltage_threshold_o(f[3:1]), .undervoltage_detect_en_o(f[0]),
    .regulator_low_power_o(rlp), .standby_flag_clear_o(sc),
    .wake_flag_clear_o(wc));
  initial forever #20 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] v, x);
    n_checks++;
    if (v !== x)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, x, v);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, s, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
    // Ack is read before this edge's updates land, as the slave saw it
    do @(posedge clk); while (ack !== 1'b1 && ++k < 50);
    if (k >= 50)
    begin
      n_mismatch++;
      test_done();
    end
    q = rd;
    {cyc, stb, we} <= 3'b000;
    // Clear pulses follow the ack edge by one cycle
    @(posedge clk);
    chk("clear", {sc, wc},
      w && a == 0 ? {d[3] & s[0], d[2] & s[0]} : 0);
  endtask : wb
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial
  begin
    #100000;
    n_mismatch++;
    test_done();
  end
  initial
  begin
    void'($urandom(32'h46B069C4));
    repeat (4) @(posedge clk);
    rst_n <= 1;
    for (i = 0; i < 60; i++)
    begin
      d = $urandom & 32'h0034_C1FF;
      a = ($urandom % 5 == 0) ? 4'h4 : 4'h0;
      s = ($urandom % 3 == 0) ? 4'hF : ($urandom % 2 ? 4'h3 : 4'hC);
      if (i == 30)
        wk <= 1;
      else
        {wk, lk, ds, os} <= {1'b0, 3'($urandom)};
      if (i > 0)
        wb(1, a, s, d);
      // Wake reload wins, so the model restarts from the reset word
      e = (i == 30 || i == 0) ? 32'h0000_8000 : e;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & 32'h0034_C1F3;
      m = lk ? m & ~32'h0000_00F0 : m;
      e = (a == 0 && i > 0 && i != 30) ? (e & ~m) | (d & m) : e;
      wb(0, a, 4'hF, 0);
      chk("word", q, a == 0 ? e : 0);
      chk("fields", f, {e[21:20], e[18], e[15:14], e[8], e[7:4]});
      chk("low power", rlp, e[0] & !os);
      chk("mode", md, ds ? {e[1], 1'b1} : 2'b00);
    end
    test_done();
  end
endmodule : pwrctl_top_tb
`default_nettype wire
